// ### core/jitter_sawtooth.sv
/*
 File: triangular jitter code generator sweeping the clock up and down.
 Assumes a step enable at JITTER_STEPS times the sweep rate; no disable exists.
*/
`timescale 1ns/1ps

module jitter_sawtooth
	import sequencer_pkg::*;
#(
	parameter int unsigned WIDTH = JITTER_WIDTH
) (
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic                    step,
	output logic signed [WIDTH-1:0]      code
);

	localparam logic signed [WIDTH-1:0] PEAK = WIDTH'((1 << (WIDTH - 1)) - 1);
	// A one-bit signed literal reads as minus one, so the step is kept at full width.
	localparam logic signed [WIDTH-1:0] ONE  = WIDTH'(1);

	logic                    rising;
	logic                    next_rising;
	logic signed [WIDTH-1:0] next_code;

	// =====================================================
	// Sweep
	// =====================================================
	// The sweep has no disable input, only the step enable, so it keeps running in every mode.
	always_comb begin
		next_code   = code;
		next_rising = rising;
		if (step) begin
			if (rising) begin
				next_code = code + ONE;
				if (code + ONE == PEAK) next_rising = 1'b0;
			end else begin
				next_code = code - ONE;
				if (code - ONE == -PEAK) next_rising = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			code   <= '0;
			rising <= 1'b1;
		end else begin
			code   <= next_code;
			rising <= next_rising;
		end
	end

endmodule

// ### core/sequencer_pkg.sv
/*
 File: constants and carrier types for the switcher fault sequencer.
 Assumes a single 200 MHz clock and comparator inputs synchronous to it.
*/
package sequencer_pkg;

	// ==========================================================
	// Time base
	// ==========================================================
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned TICK_US         = 10;            // Common time base tick in us.
	localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TICK_WIDTH      = 11;

	// ==========================================================
	// Durations (ms) and their counts in ticks
	// ==========================================================
	localparam int unsigned SOFT_START_MS   = 1;
	localparam int unsigned FAULT_TIMER_MS  = 53;
	localparam int unsigned RECOVERY_MS     = 420;
	localparam int unsigned SOFT_START_TICKS = SOFT_START_MS * 1000 / TICK_US;
	localparam int unsigned FAULT_TICKS     = FAULT_TIMER_MS * 1000 / TICK_US;
	localparam int unsigned RECOVERY_TICKS  = RECOVERY_MS * 1000 / TICK_US;
	localparam int unsigned TIMER_WIDTH     = 16;

	// ==========================================================
	// Peak current limit and jitter
	// ==========================================================
	localparam int unsigned ILIM_WIDTH      = 8;
	localparam logic [7:0]  ILIM_MAX        = 8'hff;
	localparam int unsigned JITTER_HZ       = 300;
	localparam int unsigned JITTER_PCT      = 6;
	localparam int unsigned JITTER_WIDTH    = 8;           // Signed code, +-127 is +-6 percent.
	localparam int unsigned JITTER_STEPS    = 2 * 127;     // One sweep of the triangle, up or down; a full period is twice this.
	localparam int unsigned JITTER_STEP_CYCLES = CLK_HZ / (JITTER_HZ * JITTER_STEPS);

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0] {
		ST_WAIT_SUPPLY = 3'b000,
		ST_LINE_CHECK  = 3'b001,
		ST_RUN         = 3'b010,
		ST_FAULT_OFF   = 3'b011,
		ST_OVP_OFF     = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic supply_good;     // Supply has reached its start level.
		logic feedback_fault;  // Feedback below feedback_fault_threshold.
		logic clamp_over;      // Supply clamp current above trip.
		logic line_ok;         // Drain above line_enable_level.
		logic undervoltage_lockout;            // undervoltage_lockout active.
		logic thermal;         // thermal_shutdown active.
	} comp_in_t;

	typedef struct packed {
		logic                  drive_en;
		logic [ILIM_WIDTH-1:0] peak_current_limit;
		logic signed [JITTER_WIDTH-1:0] jitter_code;
	} drive_out_t;

endpackage

// ### core/switcher_fault_sequencer.sv
/*
 File: protection and timing sequencer of an offline switching regulator.
 Assumes comparator outputs synchronous to clk and power-on reset on nrst.
*/
`timescale 1ns/1ps

// How it works
// - Drive pulses enable as soon as supply good is seen.
// - Soft-start ramps peak current limit from low to maximum over 1 ms.
// - Feedback fault comparator sets the current-limit error flag, any time.
// - The error flag starts a 53 ms fault timer.
// - Flag still set at timer end stops drive for 420 ms recovery.
// - After recovery a restart runs 53 ms before stopping if fault persists.
// - Persisting fault gives a burst with about 11 percent duty.
// - Fault clearing during restart returns to continuous switching at once.
// - Excess clamp current is an overvoltage event that stops the drivers.
// - Overvoltage keeps pulses off for the recovery interval, then restarts.
// - Overvoltage present again repeats the stop and recovery cycle forever.
// - Switching frequency is modulated by plus and minus six percent.
// - Jitter is an internal triangle sweep repeating at about 150 Hz.
// - Jitter cannot be disabled externally; it is always active.
// - On recovery from faults, drive is inhibited while line is below enable.
module switcher_fault_sequencer
	import sequencer_pkg::*;
#(
	parameter int unsigned FAULT_COUNT    = FAULT_TICKS,
	parameter int unsigned RECOVERY_COUNT = RECOVERY_TICKS,
	parameter int unsigned RAMP_COUNT     = SOFT_START_TICKS
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire comp_in_t   comp,
	output drive_out_t      drive,
	output logic            error_flag,
	output logic            ovp_active,
	output logic            fault_active
);

	// =====================================================
	// Time base and jitter
	// =====================================================
	logic tick;
	logic jitter_step;
	logic signed [JITTER_WIDTH-1:0] jitter_code;

	// Every duration counts the same tick, so only constants set the timing.
	tick_divider #(
		.DIVIDE (TICK_CYCLES),
		.WIDTH  (TICK_WIDTH)
	) u_tick (
		.clk  (clk),
		.nrst (nrst),
		.tick (tick)
	);

	tick_divider #(
		.DIVIDE (JITTER_STEP_CYCLES),
		.WIDTH  (12)
	) u_jitter_step (
		.clk  (clk),
		.nrst (nrst),
		.tick (jitter_step)
	);

	// The sweep is fed by nothing but the clock, so no mode can stop it.
	jitter_sawtooth #(
		.WIDTH (JITTER_WIDTH)
	) u_jitter (
		.clk  (clk),
		.nrst (nrst),
		.step (jitter_step),
		.code (jitter_code)
	);

	// =====================================================
	// Sequencer state
	// =====================================================
	seq_state_t             state;
	seq_state_t             next_state;
	logic [TIMER_WIDTH-1:0] timer;
	logic [TIMER_WIDTH-1:0] next_timer;
	logic [TIMER_WIDTH-1:0] fault_count;
	logic [TIMER_WIDTH-1:0] next_fault_count;
	logic [TIMER_WIDTH-1:0] ramp;
	logic [TIMER_WIDTH-1:0] next_ramp;
	logic                   next_error_flag;
	logic                   recovering;
	logic                   next_recovering;
	logic                   next_drive_en;
	logic [ILIM_WIDTH-1:0]  next_ilim;
	logic                   lockout;

	assign lockout = !comp.supply_good || comp.undervoltage_lockout || comp.thermal;

	// Sequencing of start, fault timing, recovery and overvoltage.
	// Overvoltage takes priority over the overload timer because it
	// signals a broken loop that keeps pumping energy into the supply.
	always_comb begin
		next_state       = state;
		next_timer       = timer;
		next_fault_count = fault_count;
		next_ramp        = ramp;
		next_recovering  = recovering;
		next_error_flag  = comp.feedback_fault;
		case (state)
			ST_WAIT_SUPPLY: begin
				next_ramp        = '0;
				next_fault_count = '0;
				if (!lockout) begin
					next_state = recovering ? ST_LINE_CHECK : ST_RUN;
				end
			end
			ST_LINE_CHECK: begin
				next_ramp = '0;
				if (lockout) begin
					next_state = ST_WAIT_SUPPLY;
				end else if (comp.line_ok) begin
					next_state       = ST_RUN;
					next_recovering  = 1'b0;
					next_fault_count = '0;
				end
			end
			ST_RUN: begin
				if (tick && ramp < TIMER_WIDTH'(RAMP_COUNT)) begin
					next_ramp = ramp + 1'b1;
				end
				if (!comp.feedback_fault) begin
					next_fault_count = '0;
				end else if (tick) begin
					next_fault_count = fault_count + 1'b1;
				end
				if (lockout) begin
					next_state      = ST_WAIT_SUPPLY;
					next_recovering = 1'b1;
				end else if (comp.clamp_over) begin
					next_state = ST_OVP_OFF;
					next_timer = '0;
				end else if (comp.feedback_fault && tick
						&& fault_count >= TIMER_WIDTH'(FAULT_COUNT - 1)) begin
					next_state = ST_FAULT_OFF;
					next_timer = '0;
				end
			end
			ST_FAULT_OFF, ST_OVP_OFF: begin
				next_ramp        = '0;
				next_fault_count = '0;
				next_recovering  = 1'b1;
				if (tick) begin
					next_timer = timer + 1'b1;
				end
				if (tick && timer >= TIMER_WIDTH'(RECOVERY_COUNT - 1)) begin
					next_state = ST_WAIT_SUPPLY;
				end
			end
			default: begin
				next_state = ST_WAIT_SUPPLY;
			end
		endcase
	end

	// Output decode: drive only in run, limit follows the ramp.
	always_comb begin
		next_drive_en = (next_state == ST_RUN);
		if (next_state != ST_RUN) begin
			next_ilim = '0;
		end else if (next_ramp >= TIMER_WIDTH'(RAMP_COUNT)) begin
			next_ilim = ILIM_MAX;
		end else begin
			next_ilim = ILIM_WIDTH'((32'(next_ramp) * 32'(ILIM_MAX)) / RAMP_COUNT);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state       <= ST_WAIT_SUPPLY;
			timer       <= '0;
			fault_count <= '0;
			ramp        <= '0;
			recovering  <= 1'b0;
			error_flag  <= 1'b0;
			drive       <= '0;
			ovp_active  <= 1'b0;
			fault_active <= 1'b0;
		end else begin
			state       <= next_state;
			timer       <= next_timer;
			fault_count <= next_fault_count;
			ramp        <= next_ramp;
			recovering  <= next_recovering;
			error_flag  <= next_error_flag;
			drive.drive_en           <= next_drive_en;
			drive.peak_current_limit <= next_ilim;
			drive.jitter_code        <= jitter_code;
			ovp_active   <= (next_state == ST_OVP_OFF);
			fault_active <= (next_state == ST_FAULT_OFF);
		end
	end

endmodule

// ### core/tick_divider.sv
/*
 File: divider producing a one-cycle enable pulse every DIVIDE clocks.
 Assumes one clock; each instance gives one slower rate, the tick or the jitter step.
*/
`timescale 1ns/1ps

module tick_divider #(
	parameter int unsigned DIVIDE = 2000,
	parameter int unsigned WIDTH  = 11
) (
	input  wire logic clk,
	input  wire logic nrst,
	output logic      tick
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             next_tick;

	// =====================================================
	// Counter
	// =====================================================
	// Free running, so the time base never stops with the drivers.
	always_comb begin
		if (count == WIDTH'(DIVIDE - 1)) begin
			next_count = '0;
			next_tick  = 1'b1;
		end else begin
			next_count = count + 1'b1;
			next_tick  = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

endmodule

// ### verification/comp_model.sv
/*
 Model of the comparators and supply monitor feeding the sequencer.
 Assumes the bench sets the wanted levels; each reaches comp one clock later.
*/
`timescale 1ns/1ps

// =====================================================
// Comparator bank
// =====================================================
module comp_model
	import sequencer_pkg::*;
(
	input wire logic     clk,
	input wire logic     nrst,
	input wire comp_in_t want,
	output comp_in_t     comp
);
	// Outputs settle a clock late, so the design never sees a level change on its own edge.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			comp <= '0;
		end else begin
			comp <= want;
		end
	end
endmodule

// ### verification/seq_assertions.sv
/*
 Checker for the switcher fault sequencer, watching only its top-level ports.
 Assumes the timing parameters match the instance it is bound to.
*/
`timescale 1ns/1ps

// =====================================================
// Port checker
// =====================================================
module seq_assertions
	import sequencer_pkg::*;
#(
	parameter int unsigned FAULT_COUNT    = FAULT_TICKS,
	parameter int unsigned RECOVERY_COUNT = RECOVERY_TICKS,
	parameter int unsigned RAMP_COUNT     = SOFT_START_TICKS
) (
	input wire logic       clk,
	input wire logic       nrst,
	input wire comp_in_t   comp,
	input wire drive_out_t drive,
	input wire logic       error_flag,
	input wire logic       ovp_active,
	input wire logic       fault_active
);
	localparam int unsigned OFF_LO = (RECOVERY_COUNT - 1) * TICK_CYCLES;
	localparam int unsigned OFF_HI = (RECOVERY_COUNT + 1) * TICK_CYCLES;
	// Two steps of slack; the code moves on every step, turning points of the triangle included.
	localparam int unsigned JIT_HOLD = 2 * JITTER_STEP_CYCLES + 16;

	logic [31:0]       off_cnt;
	logic [15:0]       jit_cnt;
	logic [7:0]        jit_prev;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Cycle counters measure the off interval and how long the jitter code holds still.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			off_cnt <= '0;
			jit_cnt <= '0;
			jit_prev <= '0;
		end else begin
			off_cnt <= (ovp_active || fault_active) ? off_cnt + 32'h1 : '0;
			jit_cnt <= (drive.jitter_code == jit_prev) ? jit_cnt + 16'h1 : '0;
			jit_prev <= drive.jitter_code;
		end
	end

	AST_START_CAUSE: assert property ($rose(drive.drive_en) |-> $past(comp.supply_good))
		else $error("drive enabled without supply good");
	AST_RAMP_MONO: assert property (drive.drive_en && $past(drive.drive_en)
		|-> drive.peak_current_limit >= $past(drive.peak_current_limit))
		else $error("current limit fell during run");
	AST_ERR_FOLLOW: assert property ($past(nrst) |-> error_flag == $past(comp.feedback_fault))
		else $error("error flag does not follow feedback fault");
	AST_STOP_CAUSE: assert property ($rose(fault_active) |-> $past(error_flag))
		else $error("overload stop without error flag");
	AST_OFF_QUIET: assert property ((fault_active || ovp_active)
		|-> !drive.drive_en && drive.peak_current_limit == 8'h00)
		else $error("drive active while stopped");
	AST_OFF_LENGTH: assert property ($fell(ovp_active) || $fell(fault_active)
		|-> off_cnt >= OFF_LO && off_cnt <= OFF_HI)
		else $error("recovery interval length wrong");
	AST_OVERVOLT_STOP: assert property (comp.clamp_over && drive.drive_en |=> !drive.drive_en)
		else $error("clamp trip did not stop drive");
	AST_LINE_HOLD: assert property ($fell(fault_active) ##1 !comp.line_ok |=> !drive.drive_en)
		else $error("restart with line below enable level");
	AST_JIT_RANGE: assert property (drive.jitter_code != 8'h80)
		else $error("jitter code out of range");
	AST_JIT_STEP: assert property ((drive.jitter_code - $past(drive.jitter_code))
		inside {8'h00, 8'h01, 8'hff})
		else $error("jitter code jumped");
	AST_JIT_ALIVE: assert property (jit_cnt < JIT_HOLD)
		else $error("jitter code stopped moving");
endmodule

// ### verification/switcher_fault_sequencer_tb.sv
/*
 Self-checking bench for the switcher fault sequencer with short timing counts.
 Assumes the comparator model in front of the design and the bound checker.
*/
`timescale 1ns/1ps

// =====================================================
// Bench
// =====================================================
module switcher_fault_sequencer_tb
	import sequencer_pkg::*;
;
	localparam int unsigned T = TICK_CYCLES;

	logic              clk;
	logic              nrst;
	comp_in_t          want;
	comp_in_t          comp;
	drive_out_t        drive;
	logic              error_flag;
	logic              ovp_active;
	logic              fault_active;
	logic [7:0]        j0;
	int                fails;
	int                tests_run;

	comp_model i_model (.clk(clk), .nrst(nrst), .want(want), .comp(comp));

	switcher_fault_sequencer #(.FAULT_COUNT(3), .RECOVERY_COUNT(4), .RAMP_COUNT(2)) i_dut (
		.clk(clk), .nrst(nrst), .comp(comp), .drive(drive), .error_flag(error_flag),
		.ovp_active(ovp_active), .fault_active(fault_active));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic cyc(input int unsigned n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk_b(input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic chk_v(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic close_out();
		$display("checks=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// A bounded wait for the next restart, so a stuck stop shows as a mismatch, not a hang.
	task automatic wait_on();
		int n;
		n = 0;
		while (drive.drive_en !== 1'b1 && n < 5 * T) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_start();
		want.supply_good = 1'b1;
		want.line_ok = 1'b1;
		j0 = drive.jitter_code;
		cyc(3);
		chk_b(1'b1, drive.drive_en);
		chk_v(8'h00, drive.peak_current_limit);
		// One tick into the ramp the limit must sit strictly between its ends.
		cyc(T);
		chk_b(1'b1, drive.peak_current_limit != 8'h00);
		chk_b(1'b1, drive.peak_current_limit != ILIM_MAX);
		cyc(2 * T);
		chk_v(ILIM_MAX, drive.peak_current_limit);
		chk_b(1'b1, drive.jitter_code !== j0);
	endtask

	// A one-cycle drop of the fault must restart the count, else the run stops early.
	task automatic t_glitch();
		want.feedback_fault = 1'b1;
		cyc(2);
		chk_b(1'b1, error_flag);
		cyc(5000);
		want.feedback_fault = 1'b0;
		cyc(1);
		want.feedback_fault = 1'b1;
		cyc(3000);
		chk_b(1'b1, drive.drive_en);
		cyc(3 * T);
		chk_b(1'b0, drive.drive_en);
		chk_b(1'b1, fault_active);
		chk_v(8'h00, drive.peak_current_limit);
	endtask

	task automatic t_burst();
		want.line_ok = 1'b0;
		cyc(6 * T);
		chk_b(1'b0, fault_active);
		chk_b(1'b0, drive.drive_en);
		want.line_ok = 1'b1;
		cyc(3);
		chk_b(1'b1, drive.drive_en);
		cyc(5 * T);
		chk_b(1'b0, drive.drive_en);
		chk_b(1'b1, fault_active);
	endtask

	task automatic t_resume();
		wait_on();
		chk_b(1'b1, drive.drive_en);
		want.feedback_fault = 1'b0;
		cyc(5 * T);
		chk_b(1'b1, drive.drive_en);
	endtask

	task automatic t_overvolt();
		want.clamp_over = 1'b1;
		cyc(3);
		chk_b(1'b0, drive.drive_en);
		chk_b(1'b1, ovp_active);
		want.clamp_over = 1'b0;
		cyc(5000);
		chk_b(1'b0, drive.drive_en);
		cyc(3 * T);
		chk_b(1'b1, drive.drive_en);
		want.clamp_over = 1'b1;
		cyc(5 * T);
		chk_b(1'b1, ovp_active);
	endtask

	// The run should take about 77000 cycles; the watchdog allows about 30 percent more.
	initial begin
		#500_000;
		fails++;
		close_out();
	end

	initial begin
		fails = 0;
		tests_run = 0;
		nrst = 1'b0;
		want = '0;
		repeat (8) @(posedge clk);
		#1;
		nrst = 1'b1;
		t_start();
		t_glitch();
		t_burst();
		t_resume();
		t_overvolt();
		close_out();
	end
endmodule

bind switcher_fault_sequencer seq_assertions #(.FAULT_COUNT(FAULT_COUNT),
	.RECOVERY_COUNT(RECOVERY_COUNT), .RAMP_COUNT(RAMP_COUNT)) i_chk (
	.clk(clk), .nrst(nrst), .comp(comp), .drive(drive), .error_flag(error_flag),
	.ovp_active(ovp_active), .fault_active(fault_active));
